// *** riu_pkg.sv ***
// shared constants and types for the rotate instruction unit
package riu_pkg;
    localparam int        DATA_W        = 8;
    localparam int        ADDR_W        = 8;
    localparam int        MSB_POS       = 7;
    localparam int        LSB_POS       = 0;
    localparam logic [6:0] OPC_RLNC     = 7'h11;
    localparam logic [6:0] OPC_RRC      = 7'h0C;
    localparam logic      DEST_WORK     = 1'h0;
    localparam logic      DEST_FILE     = 1'h1;
    localparam logic [7:0] WORK_RST     = 8'h00;
    localparam logic      CARRY_RST     = 1'h0;
    localparam int        QUARTERS      = 4;
    typedef enum logic [1:0] {RIU_Q1, RIU_Q2, RIU_Q3, RIU_Q4} riu_phase_t;
    typedef enum logic [1:0] {RIU_NONE, RIU_RLNC, RIU_RRC} riu_op_t;
endpackage

// *** riu_alu_if.sv ***
// interface between the sequencer and the rotate datapath
`timescale 1ns/1ps
interface riu_alu_if;
    riu_pkg::riu_op_t op;
    logic [7:0]       operand;
    logic             carry_in;
    logic [7:0]       result;
    logic             carry_out;
    modport seq (output op, output operand, output carry_in, input result, input carry_out);
    modport alu (input op, input operand, input carry_in, output result, output carry_out);
endinterface

// *** riu_rotator.sv ***
// combinational rotate datapath
`timescale 1ns/1ps
module riu_rotator
(
    riu_alu_if.alu bus
);
    always_comb
    begin
        bus.result    = bus.operand;
        bus.carry_out = bus.carry_in;
        case (bus.op)
            riu_pkg::RIU_RLNC:
            begin
                // carry untouched
                bus.result = {bus.operand[riu_pkg::MSB_POS-1:0],
                              bus.operand[riu_pkg::MSB_POS]};
            end
            riu_pkg::RIU_RRC:
            begin
                bus.result    = {bus.carry_in, bus.operand[riu_pkg::MSB_POS:1]};
                bus.carry_out = bus.operand[riu_pkg::LSB_POS];
            end
            default:
            begin
                bus.result    = bus.operand;
                bus.carry_out = bus.carry_in;
            end
        endcase
    end
endmodule

// *** riu_top.sv ***
// rotate instruction unit: decode, quarter sequencing, writeback
`timescale 1ns/1ps
module riu_top
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] instr_word,
    output logic             instr_take,
    output logic [7:0]       file_addr,
    output logic             file_rd,
    input  wire logic [7:0]  file_rdata,
    output logic             file_wr,
    output logic [7:0]       file_wdata,
    output logic [7:0]       working_register,
    output logic             carry_flag,
    output logic             op_done
);
    riu_alu_if alu_bus ();

    riu_rotator u_rot
    (
        .bus (alu_bus)
    );

    riu_pkg::riu_phase_t phase_q, phase_d;
    riu_pkg::riu_op_t    op_q, op_d;
    logic                dest_q, dest_d;
    logic [7:0]          addr_q, addr_d;
    logic [7:0]          opnd_q, opnd_d;
    logic [7:0]          res_q, res_d;
    logic                cres_q, cres_d;
    logic [7:0]          work_q, work_d;
    logic                carry_q, carry_d;
    logic                wr_q, wr_d;
    logic [7:0]          wdat_q, wdat_d;
    logic                done_q, done_d;
    riu_pkg::riu_op_t    dec_op;

    // opcode lives in bits 15:9, dest in bit 8, address in 7:0
    always_comb
    begin
        if (instr_word[15:9] == riu_pkg::OPC_RRC)
            dec_op = riu_pkg::RIU_RRC;
        else if (instr_word[15:9] == riu_pkg::OPC_RLNC)
            dec_op = riu_pkg::RIU_RLNC;
        else
            dec_op = riu_pkg::RIU_NONE;
    end

    assign alu_bus.op       = op_q;
    assign alu_bus.operand  = opnd_q;
    assign alu_bus.carry_in = carry_q;

    always_comb
    begin
        phase_d = phase_q;
        op_d    = op_q;
        dest_d  = dest_q;
        addr_d  = addr_q;
        opnd_d  = opnd_q;
        res_d   = res_q;
        cres_d  = cres_q;
        work_d  = work_q;
        carry_d = carry_q;
        wr_d    = 1'b0;
        wdat_d  = wdat_q;
        done_d  = 1'b0;
        case (phase_q)
            riu_pkg::RIU_Q1:
            begin
                op_d    = dec_op;
                dest_d  = instr_word[8];
                addr_d  = instr_word[7:0];
                phase_d = riu_pkg::RIU_Q2;
            end
            riu_pkg::RIU_Q2:
            begin
                opnd_d  = file_rdata;
                phase_d = riu_pkg::RIU_Q3;
            end
            riu_pkg::RIU_Q3:
            begin
                res_d   = alu_bus.result;
                cres_d  = alu_bus.carry_out;
                phase_d = riu_pkg::RIU_Q4;
            end
            default:
            begin
                phase_d = riu_pkg::RIU_Q1;
                if (op_q != riu_pkg::RIU_NONE)
                begin
                    done_d = 1'b1;
                    // carry only moves for the through-carry form
                    if (op_q == riu_pkg::RIU_RRC)
                        carry_d = cres_q;
                    if (dest_q == riu_pkg::DEST_FILE)
                    begin
                        wr_d   = 1'b1;
                        wdat_d = res_q;
                    end
                    else
                        work_d = res_q;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            phase_q <= riu_pkg::RIU_Q1;
            op_q    <= riu_pkg::RIU_NONE;
            dest_q  <= riu_pkg::DEST_WORK;
            addr_q  <= 8'h00;
            opnd_q  <= 8'h00;
            res_q   <= 8'h00;
            cres_q  <= riu_pkg::CARRY_RST;
            work_q  <= riu_pkg::WORK_RST;
            carry_q <= riu_pkg::CARRY_RST;
            wr_q    <= 1'b0;
            wdat_q  <= 8'h00;
            done_q  <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            op_q    <= op_d;
            dest_q  <= dest_d;
            addr_q  <= addr_d;
            opnd_q  <= opnd_d;
            res_q   <= res_d;
            cres_q  <= cres_d;
            work_q  <= work_d;
            carry_q <= carry_d;
            wr_q    <= wr_d;
            wdat_q  <= wdat_d;
            done_q  <= done_d;
        end
    end

    assign instr_take       = (phase_q == riu_pkg::RIU_Q1);
    assign file_rd          = (phase_q == riu_pkg::RIU_Q2);
    assign file_addr        = addr_q;
    assign file_wr          = wr_q;
    assign file_wdata       = wdat_q;
    assign working_register = work_q;
    assign carry_flag       = carry_q;
    assign op_done          = done_q;

    sequence s_rrc_taken;
        phase_q == riu_pkg::RIU_Q1 && instr_word[15:9] == riu_pkg::OPC_RRC;
    endsequence

    sequence s_rlnc_taken;
        phase_q == riu_pkg::RIU_Q1 && instr_word[15:9] == riu_pkg::OPC_RLNC;
    endsequence

    // anything else still runs four quarters but must leave no trace
    sequence s_other_taken;
        phase_q == riu_pkg::RIU_Q1 && instr_word[15:9] != riu_pkg::OPC_RRC &&
        instr_word[15:9] != riu_pkg::OPC_RLNC;
    endsequence

    chk_rlnc_keeps_carry: assert property (@(posedge clk) disable iff (sys_rst)
        s_rlnc_taken |-> ##4 $stable(carry_flag) ##0 op_done)
        else $error("carry moved on rotate left");
    chk_rlnc_value: assert property (@(posedge clk) disable iff (sys_rst)
        s_rlnc_taken ##1 file_rd |=> ##2
        (file_wr ? file_wdata : working_register) ==
        {$past(file_rdata[6:0],3), $past(file_rdata[7],3)})
        else $error("rotate left result wrong");
    chk_rlnc_dest: assert property (@(posedge clk) disable iff (sys_rst)
        s_rlnc_taken |-> ##4 file_wr == $past(instr_word[8],4))
        else $error("rotate left destination wrong");
    chk_rrc_carry: assert property (@(posedge clk) disable iff (sys_rst)
        s_rrc_taken ##1 file_rd |=> ##2 carry_flag == $past(file_rdata[0],3))
        else $error("carry not loaded from bit 0");
    chk_rrc_msb: assert property (@(posedge clk) disable iff (sys_rst)
        s_rrc_taken ##1 file_rd |=> ##2
        (file_wr ? file_wdata[7] : working_register[7]) == $past(carry_flag,3))
        else $error("old carry not in bit 7");
    chk_rrc_dest: assert property (@(posedge clk) disable iff (sys_rst)
        s_rrc_taken |-> ##4 file_wr == $past(instr_word[8],4))
        else $error("rotate right destination wrong");
    chk_rrc_decode: assert property (@(posedge clk) disable iff (sys_rst)
        s_rrc_taken |-> ##4 op_done ##0 (file_addr == $past(instr_word[7:0],4)))
        else $error("rotate right not decoded");
    chk_quarter_seq: assert property (@(posedge clk) disable iff (sys_rst)
        instr_take |=> file_rd ##1 !file_rd ##1 !instr_take ##1 instr_take)
        else $error("quarter sequence broken");
    chk_wr_in_q4: assert property (@(posedge clk) disable iff (sys_rst)
        file_wr |-> instr_take && $past(phase_q == riu_pkg::RIU_Q4))
        else $error("write outside fourth quarter");
    chk_rrc_low_bits: assert property (@(posedge clk) disable iff (sys_rst)
        s_rrc_taken ##1 file_rd |=> ##2
        (file_wr ? file_wdata[6:0] : working_register[6:0]) == $past(file_rdata[7:1],3))
        else $error("rotate right low bits wrong");
    chk_rlnc_addr: assert property (@(posedge clk) disable iff (sys_rst)
        s_rlnc_taken |-> ##4 file_addr == $past(instr_word[7:0],4))
        else $error("rotate left file address wrong");
    chk_work_kept: assert property (@(posedge clk) disable iff (sys_rst)
        file_wr |-> $stable(working_register))
        else $error("working register moved on file write");
    chk_refused_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        s_other_taken |-> ##4 !op_done && !file_wr && $stable(carry_flag) &&
        $stable(working_register))
        else $error("refused opcode left a trace");
    chk_done_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        op_done |=> !op_done)
        else $error("done held past one cycle");
    chk_read_addr: assert property (@(posedge clk) disable iff (sys_rst)
        instr_take |=> file_rd && file_addr == $past(instr_word[7:0]))
        else $error("read quarter address wrong");
    // the first edge after reset must open a fresh fetch with nothing pending
    chk_reset_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> instr_take && !file_wr && !op_done)
        else $error("state left over after reset");
endmodule

// *** riu_regfile_model.sv ***
// behavioural data register file serving the unit's read and write strobes
`timescale 1ns/1ps
module riu_regfile_model
(
    input  wire logic       clk,
    input  wire logic [7:0] file_addr,
    input  wire logic       file_rd,
    output logic [7:0]      file_rdata,
    input  wire logic       file_wr,
    input  wire logic [7:0] file_wdata
);
    logic [7:0] mem [0:255];
    logic [7:0] last_q = 8'h5A;
    // junk outside the read quarter, so a late sample shows up
    assign file_rdata = file_rd ? mem[file_addr] : ~last_q;
    // plain always: the bench preloads mem from its own process
    always @(posedge clk)
    begin
        if (file_rd)
            last_q <= mem[file_addr];
        if (file_wr)
            mem[file_addr] <= file_wdata;
    end
endmodule

// *** rotate_instruction_unit_tb.sv ***
// self-checking bench for the rotate instruction unit
`timescale 1ns/1ps
module rotate_instruction_unit_tb;
    logic        clk        = 1'b0;
    logic        sys_rst    = 1'b1;
    logic [15:0] instr_word = 16'h0000;
    logic        instr_take, file_rd, file_wr, carry_flag, op_done;
    logic [7:0]  file_addr, file_rdata, file_wdata, working_register;
    int          bad_count   = 0;
    int          check_count = 0;
    int          cycles      = 0;

    riu_top DUT (.clk(clk), .sys_rst(sys_rst), .instr_word(instr_word),
        .instr_take(instr_take), .file_addr(file_addr), .file_rd(file_rd),
        .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata),
        .working_register(working_register), .carry_flag(carry_flag), .op_done(op_done));
    riu_regfile_model PM (.clk(clk), .file_addr(file_addr), .file_rd(file_rd),
        .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata));

    always #20 clk = ~clk;

    task automatic finish_test();
        $display("checks=%0d bad=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // the whole test takes far fewer cycles than this ceiling
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one instruction: preload operand, issue for the next take edge, judge its result
    task automatic run(input logic [6:0] opc, input logic d, input logic [7:0] adr,
                       input logic [7:0] val, input logic [7:0] res, input logic c);
        logic [7:0] w_old;
        logic       ok;
        PM.mem[adr] = val;
        w_old = working_register;
        ok = (opc === riu_pkg::OPC_RLNC) || (opc === riu_pkg::OPC_RRC);
        // find a take cycle off the edge, then load for the following one
        while (instr_take !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        instr_word <= {opc, d, adr};
        repeat (4) @(posedge clk);
        instr_word <= 16'h0000;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(op_done, 8'h00);
        @(negedge clk);
        chk(op_done, ok);
        chk(file_wr, ok & d);
        if (ok && d)
        begin
            chk(file_wdata, res);
            chk(file_addr, adr);
        end
        chk(working_register, (ok && !d) ? res : w_old);
        chk(carry_flag, c);
    endtask

    task automatic test_reset();
        chk(working_register, riu_pkg::WORK_RST);
        chk(carry_flag, riu_pkg::CARRY_RST);
    endtask

    task automatic test_rotates();
        run(riu_pkg::OPC_RLNC, 1'b1, 8'h21, 8'hEB, 8'hD7, 1'b0);
        @(negedge clk);
        chk(PM.mem[8'h21], 8'hD7);
        run(riu_pkg::OPC_RLNC, 1'b0, 8'hFF, 8'h80, 8'h01, 1'b0);
        run(riu_pkg::OPC_RRC, 1'b0, 8'h10, 8'hE6, 8'h73, 1'b0);
        run(riu_pkg::OPC_RRC, 1'b1, 8'h00, 8'h01, 8'h00, 1'b1);
        @(negedge clk);
        chk(PM.mem[8'h00], 8'h00);
        // carry now set: left rotate must not touch it
        run(riu_pkg::OPC_RLNC, 1'b0, 8'h05, 8'h7F, 8'hFE, 1'b1);
        run(riu_pkg::OPC_RRC, 1'b0, 8'hFF, 8'h00, 8'h80, 1'b0);
    endtask

    task automatic test_refused();
        run(7'h0D, 1'b1, 8'hFF, 8'h55, 8'h00, 1'b0);
        @(negedge clk);
        chk(PM.mem[8'hFF], 8'h55);
        run(7'h1C, 1'b0, 8'h01, 8'h01, 8'h00, 1'b0);
    endtask

    // reset in mid-run must clear working register and carry again
    task automatic test_midreset();
        run(riu_pkg::OPC_RRC, 1'b0, 8'h33, 8'h03, 8'h01, 1'b1);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk(instr_take, 8'h01);
        chk(op_done, 8'h00);
        test_reset();
        run(riu_pkg::OPC_RLNC, 1'b0, 8'h33, 8'h81, 8'h03, 1'b0);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        test_reset();
        test_rotates();
        test_refused();
        test_midreset();
        finish_test();
    end
endmodule
